// file: verilog/timer_clock_clear_buffer_ctl.sv
// counter clock, clear and buffer control for the five-channel timer
module timer_clock_clear_buffer_ctl import timer_ctl_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic standby,
	input wire logic [3:0] bus_sel,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [1:0] bus_be,
	input wire logic [15:0] bus_wdata,
	output logic [15:0] bus_rdata,
	input wire logic ext_clock_in_a,
	input wire logic ext_clock_in_b,
	input wire logic ext_clock_in_c,
	input wire logic ext_clock_in_d,
	input wire logic phase_count_mode_flag,
	input wire logic phase_step,
	input wire logic [NUM_BUF-1:0] buffer_enable,
	input wire logic [NUM_CH-1:0] sync_member,
	input wire logic [NUM_CH-1:0] capture_role_a,
	input wire logic [NUM_CH-1:0] capture_role_b,
	input wire logic [NUM_CH-1:0] event_a,
	input wire logic [NUM_CH-1:0] event_b,
	input wire logic [16*NUM_BUF-1:0] gr_value,
	output logic [NUM_CH-1:0] count_tick,
	output logic [NUM_CH-1:0] counter_clear,
	output logic [NUM_BUF-1:0] gr_load,
	output logic [16*NUM_BUF-1:0] gr_load_value
);
	localparam int PHASE_CH = 2;

	logic [7:0] ctl [NUM_CH];
	logic [PSC_WIDTH-1:0] prescale;
	logic [NUM_EXT-1:0] ext_meta;
	logic [NUM_EXT-1:0] ext_sync;
	logic [15:0] buf_value [NUM_BUF];
	logic [NUM_BUF-1:0] buf_load;
	logic [15:0] buf_load_value [NUM_BUF];
	logic [NUM_CH-1:0] unit_tick;
	logic [NUM_CH-1:0] next_tick;
	logic [NUM_CH-1:0] source_clear;
	logic [NUM_CH-1:0] next_clear;
	logic [15:0] ctl_read [NUM_CH];

	wire [NUM_EXT-1:0] ext_pins = {ext_clock_in_d, ext_clock_in_c,
		ext_clock_in_b, ext_clock_in_a};
	wire bus_is_ctl = bus_sel < REG_CTL_BASE + 4'(NUM_CH);
	wire bus_is_buf = bus_sel >= REG_BUF_BASE && bus_sel < REG_BUF_BASE + 4'(NUM_BUF);
	wire [1:0] buf_index = 2'(bus_sel - REG_BUF_BASE);
	wire [2:0] ctl_index = 3'(bus_sel - REG_CTL_BASE);
	wire [15:0] read_mux = bus_is_ctl ? ctl_read[ctl_index] :
		(bus_is_buf ? buf_value[buf_index] : 16'h0000);

	// pin synchroniser and free-running prescaler
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ext_meta <= '0;
			ext_sync <= '0;
			prescale <= '0;
		end else begin
			ext_meta <= ext_pins;
			ext_sync <= ext_meta;
			prescale <= prescale + 3'h1;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			wire [2:0] psc = ctl[ch][PRESCALE_SELECT_2:PRESCALE_SELECT_0];
			wire [1:0] edge_mode = ctl[ch][EDGE_SELECT_HI:EDGE_SELECT_LO];
			wire [1:0] clr_sel = ctl[ch][CLEAR_SELECT_HI:CLEAR_SELECT_LO];
			wire use_ext = psc[PRESCALE_SELECT_2];
			wire every_cycle = ~use_ext && psc[1:0] == PSC_UNDIVIDED;
			wire int_level = psc[1:0] == PSC_UNDIVIDED ? 1'b0 :
				prescale[2'(psc[1:0] - 2'h1)];
			wire src_level = use_ext ? ext_sync[psc[1:0]] : int_level;
			wire phase_mode = ch == PHASE_CH && phase_count_mode_flag;
			wire [NUM_CH-1:0] others = sync_member & ~(NUM_CH'(1) << ch);

			count_edge_unit u_edge (
				.clk_sys(clk_sys),
				.reset(reset),
				.src_level(src_level),
				.every_cycle(every_cycle),
				.internal_src(~use_ext),
				.edge_mode(edge_mode),
				.tick(unit_tick[ch])
			);

			// phase inputs replace prescaler and edge choice
			assign next_tick[ch] = phase_mode ? phase_step : unit_tick[ch];
			// event covers compare match or capture per role
			assign source_clear[ch] = (clr_sel == CLR_GRA && event_a[ch]) ||
				(clr_sel == CLR_GRB && event_b[ch]);
			assign next_clear[ch] = source_clear[ch] || (clr_sel == CLR_SYNC &&
				sync_member[ch] && |(source_clear & others));
			assign ctl_read[ch] = {8'h00, ctl[ch]};

			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					ctl[ch] <= CTL_RESET;
				end else if (standby) begin
					ctl[ch] <= CTL_RESET;
				end else if (bus_wr && bus_is_ctl && ctl_index == 3'(ch) && bus_be[0]) begin
					ctl[ch] <= bus_wdata[7:0];
				end
			end
		end
	endgenerate

	genvar bi;
	generate
		for (bi = 0; bi < NUM_BUF; bi++) begin : g_buf
			// slots: 0 ch3 a, 1 ch3 b, 2 ch4 a, 3 ch4 b
			localparam int BUF_CH = 3 + bi / 2;
			wire is_b = bi % 2 == 1;
			wire role = is_b ? capture_role_b[BUF_CH] : capture_role_a[BUF_CH];
			wire gr_evt = is_b ? event_b[BUF_CH] : event_a[BUF_CH];
			wire wr_hit = bus_wr && bus_is_buf && buf_index == 2'(bi);

			buffer_slot_unit u_slot (
				.clk_sys(clk_sys),
				.reset(reset),
				.standby(standby),
				.wr_en(wr_hit),
				.be(bus_be),
				.wdata(bus_wdata),
				.enable(buffer_enable[bi]),
				.capture_role(role),
				.gr_event(gr_evt),
				.gr_value(gr_value[16*bi +: 16]),
				.value(buf_value[bi]),
				.load(buf_load[bi]),
				.load_value(buf_load_value[bi])
			);

			assign gr_load[bi] = buf_load[bi];
			assign gr_load_value[16*bi +: 16] = buf_load_value[bi];
		end
	endgenerate

	// registered outputs and read data
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_tick <= '0;
			counter_clear <= '0;
			bus_rdata <= 16'h0000;
		end else if (standby) begin
			// standby silences counting and clearing
			count_tick <= '0;
			counter_clear <= '0;
		end else begin
			count_tick <= next_tick;
			counter_clear <= next_clear;
			bus_rdata <= bus_rd ? read_mux : bus_rdata;
		end
	end
endmodule : timer_clock_clear_buffer_ctl

// file: verilog/timer_ctl_pkg.sv
// constants shared by the timer clock, clear and buffer control
package timer_ctl_pkg;
	localparam int NUM_CH = 5;
	localparam int NUM_BUF = 4;
	localparam int NUM_EXT = 4;
	localparam int PSC_WIDTH = 3;
	// register indices on the internal 16-bit bus
	localparam logic [3:0] REG_CTL_BASE = 4'h0;
	localparam logic [3:0] REG_BUF_BASE = 4'h8;
	localparam logic [3:0] REG_CH3_BUFFER_A = 4'h8;
	localparam logic [3:0] REG_CH3_BUFFER_B = 4'h9;
	localparam logic [3:0] REG_CH4_BUFFER_A = 4'ha;
	localparam logic [3:0] REG_CH4_BUFFER_B = 4'hb;
	// reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] BUF_RESET = 16'hffff;
	// control field positions
	localparam int CTL_RSVD_BIT = 7;
	localparam int CLEAR_SELECT_HI = 6;
	localparam int CLEAR_SELECT_LO = 5;
	localparam int EDGE_SELECT_HI = 4;
	localparam int EDGE_SELECT_LO = 3;
	localparam int PRESCALE_SELECT_2 = 2;
	localparam int PRESCALE_SELECT_0 = 0;
	// clear source encodings
	typedef enum logic [1:0] {
		CLR_NONE = 2'h0,
		CLR_GRA = 2'h1,
		CLR_GRB = 2'h2,
		CLR_SYNC = 2'h3
	} clear_sel_t;
	// edge select encodings, 1x means both
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	// internal prescaler code for the undivided clock
	localparam logic [1:0] PSC_UNDIVIDED = 2'h0;

	// byte-lane merge for word or byte writes
	function automatic logic [15:0] byte_merge(input logic [15:0] old_value,
		input logic [15:0] wdata, input logic [1:0] be);
		byte_merge = {be[1] ? wdata[15:8] : old_value[15:8],
			be[0] ? wdata[7:0] : old_value[7:0]};
	endfunction : byte_merge
endpackage : timer_ctl_pkg

// file: verilog/count_edge_unit.sv
// count edge selection for one channel clock source
module count_edge_unit import timer_ctl_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic src_level,
	input wire logic every_cycle,
	input wire logic internal_src,
	input wire logic [1:0] edge_mode,
	output logic tick
);
	logic prev_level;
	wire rise = src_level & ~prev_level;
	wire fall = ~src_level & prev_level;
	wire ext_tick = edge_mode[1] ? (rise | fall) :
		(edge_mode[0] ? fall : rise);
	// divided internal sources count falling edges only, the undivided clock ticks every cycle
	assign tick = every_cycle | (internal_src ? fall : ext_tick);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prev_level <= 1'b0;
		end else begin
			prev_level <= src_level;
		end
	end
endmodule : count_edge_unit

// file: verilog/buffer_slot_unit.sv
// one buffer register paired with a general register
module buffer_slot_unit import timer_ctl_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic standby,
	input wire logic wr_en,
	input wire logic [1:0] be,
	input wire logic [15:0] wdata,
	input wire logic enable,
	input wire logic capture_role,
	input wire logic gr_event,
	input wire logic [15:0] gr_value,
	output logic [15:0] value,
	output logic load,
	output logic [15:0] load_value
);
	// role follows the paired register, no own setting
	wire do_capture = enable & capture_role & gr_event;
	wire do_compare = enable & ~capture_role & gr_event;
	wire [15:0] next_value = do_capture ? gr_value :
		(wr_en ? byte_merge(value, wdata, be) : value);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			value <= BUF_RESET;
			load <= 1'b0;
			load_value <= BUF_RESET;
		end else if (standby) begin
			value <= BUF_RESET;
			load <= 1'b0;
			load_value <= BUF_RESET;
		end else begin
			value <= next_value;
			load <= do_compare;
			load_value <= value;
		end
	end
endmodule : buffer_slot_unit

// file: tb/timer_ctl_monitor.sv
// concurrent checks on the timer control ports
module timer_ctl_monitor import timer_ctl_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic standby,
	input wire logic bus_rd,
	input wire logic [15:0] bus_rdata,
	input wire logic [NUM_BUF-1:0] buffer_enable,
	input wire logic [NUM_CH-1:0] capture_role_a,
	input wire logic [NUM_CH-1:0] capture_role_b,
	input wire logic [NUM_CH-1:0] event_a,
	input wire logic [NUM_CH-1:0] event_b,
	input wire logic [NUM_CH-1:0] counter_clear,
	input wire logic [NUM_BUF-1:0] gr_load,
	input wire logic phase_count_mode_flag,
	input wire logic phase_step,
	input wire logic [NUM_CH-1:0] count_tick
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	a_standby_quiet: assert property (standby |=> gr_load == '0 && counter_clear == '0)
		else $error("output active during standby");
	a_rdata_hold: assert property (!$past(bus_rd) && !standby && !$past(standby) |-> $stable(bus_rdata))
		else $error("read data changed without read");
	a_load_match: assert property (event_a[3] && buffer_enable[0] && !capture_role_a[3] && !standby |=> gr_load[0])
		else $error("no load on compare match");
	a_load_cause: assert property (gr_load[0] |-> $past(event_a[3]) && $past(buffer_enable[0]) && !$past(capture_role_a[3]))
		else $error("load without compare match");
	a_load_slot3: assert property (event_b[4] && buffer_enable[3] && !capture_role_b[4] && !standby |=> gr_load[3])
		else $error("no load on slot three");
	a_no_capload: assert property (event_a[4] && capture_role_a[4] |=> !gr_load[2])
		else $error("load on capture");
	a_disabled_idle: assert property (!buffer_enable[1] |=> !gr_load[1])
		else $error("load from disabled buffer");
	a_clear_cause: assert property (|counter_clear |-> $past(event_a) != '0 || $past(event_b) != '0)
		else $error("clear without event");
	a_phase_tick: assert property (phase_count_mode_flag && !standby |=> count_tick[2] == $past(phase_step))
		else $error("channel two tick not from phase input");
endmodule : timer_ctl_monitor

bind timer_clock_clear_buffer_ctl timer_ctl_monitor i_timer_ctl_monitor (
	.clk_sys(clk_sys), .reset(reset), .standby(standby), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .buffer_enable(buffer_enable), .capture_role_a(capture_role_a),
	.capture_role_b(capture_role_b), .event_a(event_a), .event_b(event_b),
	.counter_clear(counter_clear), .gr_load(gr_load),
	.phase_count_mode_flag(phase_count_mode_flag), .phase_step(phase_step),
	.count_tick(count_tick)
);

// file: tb/tb_top.sv
// register-level testbench for the timer control
module tb_top import timer_ctl_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, reset = 1, standby = 0, bus_wr = 0, bus_rd = 0;
	logic [3:0] bus_sel = 4'h0;
	logic [1:0] bus_be = 2'h0;
	logic [15:0] bus_wdata = 16'h0000, bus_rdata;
	logic ext_clock_in_a = 0, ext_clock_in_b = 0, phase_count_mode_flag = 0, phase_step = 0;
	logic [3:0] buffer_enable = 4'h0, gr_load;
	logic [4:0] sync_member = 5'h00, capture_role_a = 5'h00, event_a = 5'h00, event_b = 5'h00;
	logic [4:0] count_tick, counter_clear;
	logic [63:0] gr_value = 64'h0000_0000_0000_0000, gr_load_value;
	logic [7:0] codes [6] = '{8'h04, 8'h0c, 8'h14, 8'h05, 8'h06, 8'h07};
	int exps [6] = '{4, 4, 8, 8, 4, 8};
	int error_cnt = 0, n_tests = 0, k;
	timer_clock_clear_buffer_ctl i_timer_clock_clear_buffer_ctl (.clk_sys(clk_sys),
		.reset(reset), .standby(standby), .bus_sel(bus_sel), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.ext_clock_in_a(ext_clock_in_a), .ext_clock_in_b(ext_clock_in_b),
		.ext_clock_in_c(ext_clock_in_a), .ext_clock_in_d(ext_clock_in_b),
		.phase_count_mode_flag(phase_count_mode_flag), .phase_step(phase_step),
		.buffer_enable(buffer_enable), .sync_member(sync_member),
		.capture_role_a(capture_role_a), .capture_role_b(5'h00), .event_a(event_a),
		.event_b(event_b), .gr_value(gr_value), .count_tick(count_tick),
		.counter_clear(counter_clear), .gr_load(gr_load), .gr_load_value(gr_load_value));
	always #2 clk_sys = ~clk_sys;
	task automatic report_and_stop();
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] s, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk_sys);
		bus_sel <= s;
		bus_be <= be;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] s, input logic [15:0] exp, input string what);
		@(posedge clk_sys);
		bus_sel <= s;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1 chk(what, exp, bus_rdata);
	endtask : rd_reg
	task automatic ev(input logic [4:0] a, input logic [4:0] b);
		@(posedge clk_sys);
		event_a <= a;
		event_b <= b;
		@(posedge clk_sys);
		event_a <= 5'h00;
		event_b <= 5'h00;
		#1;
	endtask : ev
	task automatic cnt(input int ch, input int n, input int ext);
		k = 0;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			ext_clock_in_a <= ext != 0 && i < 32 && i[2];
			ext_clock_in_b <= ext != 0 && i < 32 && i[1];
			#1 k += count_tick[ch];
		end
	endtask : cnt
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 8; i < 12; i++) rd_reg(4'(i), 16'hffff, "buffer");
		for (int i = 0; i < 5; i++) rd_reg(4'(i), 16'h0000, "control");
		wr_reg(4'hc, 2'b11, 16'h5a5a);
		rd_reg(4'hc, 16'h0000, "unmapped");
		wr_reg(4'h0, 2'b01, 16'hffa0);
		rd_reg(4'h0, 16'h00a0, "control top bit");
		wr_reg(4'h8, 2'b11, 16'h1234);
		wr_reg(4'h8, 2'b10, 16'hab00);
		wr_reg(4'hb, 2'b01, 16'h0077);
		rd_reg(4'h8, 16'hab34, "buffer byte");
		rd_reg(4'hb, 16'hff77, "buffer byte");
		@(posedge clk_sys);
		buffer_enable <= 4'b1101;
		capture_role_a <= 5'h10;
		gr_value <= 64'h0000_5555_0000_0000;
		ev(5'h18, 5'h18);
		chk("gr_load", 16'h0009, {12'h000, gr_load});
		chk("load value a", 16'hab34, gr_load_value[15:0]);
		chk("load value d", 16'hff77, gr_load_value[63:48]);
		rd_reg(4'ha, 16'h5555, "capture buffer");
		wr_reg(4'h1, 2'b01, 16'h0060);
		wr_reg(4'h2, 2'b01, 16'h0040);
		sync_member <= 5'h03;
		ev(5'h05, 5'h00);
		chk("clear", 16'h0003, {11'h000, counter_clear});
		ev(5'h00, 5'h04);
		chk("clear", 16'h0004, {11'h000, counter_clear});
		@(posedge clk_sys);
		phase_count_mode_flag <= 1'b1;
		cnt(2, 10, 0);
		chk("phase ticks", 16'h0000, 16'(k));
		@(posedge clk_sys);
		phase_step <= 1'b1;
		cnt(2, 10, 0);
		chk("phase ticks", 16'h000a, 16'(k));
		@(posedge clk_sys);
		phase_step <= 1'b0;
		phase_count_mode_flag <= 1'b0;
		cnt(4, 10, 0);
		chk("ticks", 16'h000a, 16'(k));
		wr_reg(4'h3, 2'b01, 16'h0001);
		cnt(3, 16, 0);
		chk("ticks", 16'h0008, 16'(k));
		wr_reg(4'h3, 2'b01, 16'h001b);
		cnt(3, 16, 0);
		chk("ticks", 16'h0002, 16'(k));
		for (int j = 0; j < 6; j++) begin
			wr_reg(4'h3, 2'b01, {8'h00, codes[j]});
			cnt(3, 40, 1);
			chk("ext ticks", 16'(exps[j]), 16'(k));
		end
		@(posedge clk_sys);
		standby <= 1'b1;
		@(posedge clk_sys);
		standby <= 1'b0;
		rd_reg(4'h8, 16'hffff, "standby buffer");
		rd_reg(4'h0, 16'h0000, "standby control");
		report_and_stop();
	end
endmodule : tb_top
